// ==== inc/wmes_pkg.sv ====
// package of offsets, field layouts, reset values and shared helpers for the wake mask block
package wmes_pkg;

    // latched source registers
    localparam logic [15:0] WMES_ADDR_SRC_ONE = 16'h7f2a;
    localparam logic [15:0] WMES_ADDR_SRC_TWO = 16'h7f2b;
    localparam logic [15:0] WMES_ADDR_SRC_FOUR = 16'h7f59;
    localparam logic [15:0] WMES_ADDR_SRC_FIVE = 16'h7f5e;
    localparam logic [15:0] WMES_ADDR_SRC_SIX = 16'h7f63;
    localparam logic [15:0] WMES_ADDR_SRC_SEVEN = 16'h7f64;
    localparam logic [15:0] WMES_ADDR_SRC_EIGHT = 16'h7f55;

    // mask, edge select and hibernation registers
    localparam logic [15:0] WMES_ADDR_MASK_ONE = 16'h7f2c;
    localparam logic [15:0] WMES_ADDR_MASK_TWO = 16'h7f2d;
    localparam logic [15:0] WMES_ADDR_MASK_EIGHT = 16'h7f56;
    localparam logic [15:0] WMES_ADDR_EDGE_G0_LOW = 16'h7f57;
    localparam logic [15:0] WMES_ADDR_MASK_FOUR = 16'h7f5a;
    localparam logic [15:0] WMES_ADDR_MASK_FIVE = 16'h7f5f;
    localparam logic [15:0] WMES_ADDR_MASK_SEVEN = 16'h7f65;
    localparam logic [15:0] WMES_ADDR_MASK_SIX = 16'h7f66;
    localparam logic [15:0] WMES_ADDR_HIB_COUNT = 16'h7ff3;

    localparam logic [7:0] WMES_REG_RESET = 8'h00;
    localparam logic [7:0] WMES_TWO_VALID = 8'h7f;
    localparam logic [7:0] WMES_SEVEN_VALID = 8'h07;

    // group two bit positions
    localparam int WMES_B2_RING = 6;
    localparam int WMES_B2_EVT_FOUR = 5;
    localparam int WMES_B2_EVT_TWO = 4;
    localparam int WMES_B2_EVT_THREE = 3;
    localparam int WMES_B2_HIB = 2;
    localparam int WMES_B2_ANY_KEY = 1;
    localparam int WMES_B2_GP_PIN = 0;

    // selectable sources: three groups of eight, first four edges programmable
    localparam int WMES_SEL_GROUPS = 3;
    localparam int WMES_SEL_PER_GROUP = 8;
    localparam int WMES_SEL_PROG = 4;

    // hibernation step: 30 s of the 32 kHz clock
    localparam int WMES_SLOW_CLK_HZ = 32768;
    localparam int WMES_HIB_STEP_SEC = 30;
    localparam int WMES_HIB_STEP_TICKS = WMES_SLOW_CLK_HZ * WMES_HIB_STEP_SEC;

    typedef enum logic [1:0] {
        WMES_EDGE_FALL = 2'b00,
        WMES_EDGE_RISE = 2'b01,
        WMES_EDGE_EITHER = 2'b10,
        WMES_EDGE_RSVD = 2'b11
    } wmes_edge_t;

    typedef enum logic {
        WMES_HIB_IDLE = 1'b0,
        WMES_HIB_RUN = 1'b1
    } wmes_hib_state_t;

    typedef struct packed {
        logic pm_control_two;
        logic pm_enable_two;
        logic pm_status_two;
        logic twowire_one;
        logic twowire_two;
        logic infrared_receive_wake;
        logic ext_event_one;
        logic clock_alarm_wake;
        logic serial_ring_indicate;
        logic ext_event_four;
        logic ext_event_two;
        logic ext_event_three;
        logic any_key_wake;
        logic general_wake_pin_n;
        logic floppy_on_parallel_wake;
        logic fan_tach_two;
        logic fan_tach_one;
        logic [7:0] legacy_pin_wake_bits;
    } wmes_fixed_src_t;

    // latched bit: set wins over a write-one clear in the same cycle
    function automatic logic [7:0] wmes_w1c(input logic [7:0] q, input logic [7:0] set,
                                           input logic clr_en, input logic [7:0] clr);
        wmes_w1c = (q & ~(clr_en ? clr : 8'h00)) | set;
    endfunction : wmes_w1c

    function automatic logic wmes_any_open(input logic [7:0] src, input logic [7:0] mask);
        wmes_any_open = |(src & ~mask);
    endfunction : wmes_any_open

endpackage : wmes_pkg

// ==== src/wmes_edge_detect.sv ====
// per-input edge detector with a two-bit edge select for each input
`timescale 1ns/100ps
`default_nettype none
module wmes_edge_detect
    import wmes_pkg::*;
#(
    parameter int N = 8
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [N-1:0] level_in,
    input wire logic [2*N-1:0] edge_sel,
    output logic [N-1:0] hit_q
);
    logic [N-1:0] prev_in_q;
    logic [N-1:0] prev_adj_q;
    logic [N-1:0] adj;
    logic [N-1:0] hit_d;
    logic primed_q;

    // the polarity-adjusted level makes a select change look like an edge, as on the real part
    always_comb begin
        for (int i = 0; i < N; i++) begin
            adj[i] = (wmes_edge_t'(edge_sel[2*i +: 2]) == WMES_EDGE_FALL) ? ~level_in[i]
                                                                         : level_in[i];
            case (wmes_edge_t'(edge_sel[2*i +: 2]))
                WMES_EDGE_FALL, WMES_EDGE_RISE: hit_d[i] = primed_q & adj[i] & ~prev_adj_q[i];
                WMES_EDGE_EITHER: hit_d[i] = primed_q & (level_in[i] ^ prev_in_q[i]);
                default: hit_d[i] = 1'b0;
            endcase
        end
    end

    // first cycle after reset only samples, so a high input is not taken as an edge
    always_ff @(posedge clk) begin
        if (reset) begin
            primed_q <= 1'b0;
            prev_in_q <= '0;
            prev_adj_q <= '0;
            hit_q <= '0;
        end else begin
            primed_q <= 1'b1;
            prev_in_q <= level_in;
            prev_adj_q <= adj;
            hit_q <= hit_d;
        end
    end

endmodule : wmes_edge_detect
`default_nettype wire

// ==== src/wmes_hib_timer.sv ====
// hibernation countdown: 8-bit down-counter stepped every 30 s of the 32 kHz clock
`timescale 1ns/100ps
`default_nettype none
module wmes_hib_timer
    import wmes_pkg::*;
#(
    parameter int STEP_TICKS = WMES_HIB_STEP_TICKS
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic slow_clk_32k,
    input wire logic load,
    input wire logic [7:0] load_val,
    output logic [7:0] count_q,
    output logic expire_q
);
    wmes_hib_state_t state_q;
    logic slow_prev_q;
    logic [31:0] presc_q;
    logic slow_tick;
    logic step;

    assign slow_tick = slow_clk_32k & ~slow_prev_q;
    assign step = slow_tick && (presc_q == 32'(STEP_TICKS - 1));

    always_ff @(posedge clk) begin
        if (reset) begin
            slow_prev_q <= 1'b0;
        end else begin
            slow_prev_q <= slow_clk_32k;
        end
    end

    // prescaler restarts on every load so the first step is a full 30 s
    always_ff @(posedge clk) begin
        if (reset || load || state_q == WMES_HIB_IDLE) begin
            presc_q <= '0;
        end else if (slow_tick) begin
            presc_q <= step ? 32'h0 : presc_q + 32'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_q <= WMES_HIB_IDLE;
            count_q <= WMES_REG_RESET;
            expire_q <= 1'b0;
        end else begin
            expire_q <= 1'b0;
            case (state_q)
                WMES_HIB_IDLE: begin
                    if (load) begin
                        count_q <= load_val;
                        state_q <= (load_val != 8'h00) ? WMES_HIB_RUN : WMES_HIB_IDLE;
                    end
                end
                WMES_HIB_RUN: begin
                    if (load) begin
                        count_q <= load_val;
                        state_q <= (load_val != 8'h00) ? WMES_HIB_RUN : WMES_HIB_IDLE;
                    end else if (step) begin
                        count_q <= count_q - 8'h01;
                        if (count_q == 8'h01) begin
                            state_q <= WMES_HIB_IDLE;
                            expire_q <= 1'b1;
                        end
                    end
                end
                default: state_q <= WMES_HIB_IDLE;
            endcase
        end
    end

    chk_hib_holds_zero: assert property (@(posedge clk) disable iff (reset)
        (count_q == 8'h00 && !load) |=> (count_q == 8'h00 && !expire_q))
        else $error("hibernation count left zero without a load");

    chk_hib_load_start: assert property (@(posedge clk) disable iff (reset)
        (load && load_val != 8'h00) |=> (count_q == $past(load_val) && state_q == WMES_HIB_RUN))
        else $error("non-zero hibernation load did not start the count");

endmodule : wmes_hib_timer
`default_nettype wire

// ==== src/wmes_top.sv ====
// wake-up mask, edge select and hibernation timer block for the embedded controller
`timescale 1ns/100ps
`default_nettype none
module wmes_top
    import wmes_pkg::*;
#(
    parameter int HIB_STEP_TICKS = WMES_HIB_STEP_TICKS
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [15:0] cpu_addr,
    input wire logic cpu_wr,
    input wire logic cpu_rd,
    input wire logic [7:0] cpu_wdata,
    output logic [7:0] cpu_rdata,
    output logic cpu_rvalid,
    input wire logic slow_clk_32k,
    input wire wmes_fixed_src_t fixed_src,
    input wire logic [23:0] selectable_wake_src,
    output logic wake_irq,
    output logic ext_irq_line_a,
    output logic ext_irq_line_b,
    output logic ext_irq_line_c
);
    // mask registers, one per source register
    logic [7:0] mask_one_q;
    logic [7:0] mask_two_q;
    logic [7:0] mask_four_q;
    logic [7:0] mask_five_q;
    logic [7:0] mask_six_q;
    logic [7:0] mask_seven_q;
    logic [7:0] mask_eight_q;
    logic [7:0] edge_g0_low_q;

    // latched sources
    logic [7:0] src_one_q;
    logic [7:0] src_two_q;
    logic [7:0] src_four_q;
    logic [7:0] src_five_q;
    logic [7:0] src_six_q;
    logic [7:0] src_seven_q;
    logic [7:0] src_eight_q;

    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic rvalid_q;
    logic wake_irq_q;
    logic line_a_q;
    logic line_b_q;
    logic line_c_q;

    logic [7:0] hib_count;
    logic hib_expire;
    logic hib_load;
    logic [47:0] sel_edge_cfg;
    logic [23:0] sel_hit;
    logic [2:0] evt_hit;
    logic [7:0] set_one;
    logic [7:0] set_two;
    logic [7:0] set_seven;

    function automatic logic wr_at(input logic [15:0] a);
        wr_at = cpu_wr && (cpu_addr == a);
    endfunction : wr_at

    // mask register writes
    always_ff @(posedge clk) begin
        if (reset) begin
            mask_one_q <= WMES_REG_RESET;
            mask_two_q <= WMES_REG_RESET;
            mask_four_q <= WMES_REG_RESET;
            mask_five_q <= WMES_REG_RESET;
            mask_six_q <= WMES_REG_RESET;
            mask_seven_q <= WMES_REG_RESET;
            mask_eight_q <= WMES_REG_RESET;
        end else begin
            if (wr_at(WMES_ADDR_MASK_ONE)) mask_one_q <= cpu_wdata;
            if (wr_at(WMES_ADDR_MASK_TWO)) mask_two_q <= cpu_wdata & WMES_TWO_VALID;
            if (wr_at(WMES_ADDR_MASK_FOUR)) mask_four_q <= cpu_wdata;
            if (wr_at(WMES_ADDR_MASK_FIVE)) mask_five_q <= cpu_wdata;
            if (wr_at(WMES_ADDR_MASK_SIX)) mask_six_q <= cpu_wdata;
            if (wr_at(WMES_ADDR_MASK_SEVEN)) mask_seven_q <= cpu_wdata & WMES_SEVEN_VALID;
            if (wr_at(WMES_ADDR_MASK_EIGHT)) mask_eight_q <= cpu_wdata;
        end
    end

    // edge select for selectable sources 0 to 3
    always_ff @(posedge clk) begin
        if (reset) begin
            edge_g0_low_q <= WMES_REG_RESET;
        end else if (wr_at(WMES_ADDR_EDGE_G0_LOW)) begin
            edge_g0_low_q <= cpu_wdata;
        end
    end

    // sources without a select register here keep the reset choice, falling edge
    always_comb begin
        sel_edge_cfg = '0;
        sel_edge_cfg[2*WMES_SEL_PROG-1:0] = edge_g0_low_q;
    end

    wmes_edge_detect #(
        .N(WMES_SEL_GROUPS * WMES_SEL_PER_GROUP)
    ) u_sel_edges (
        .clk(clk),
        .reset(reset),
        .level_in(selectable_wake_src),
        .edge_sel(sel_edge_cfg),
        .hit_q(sel_hit)
    );

    // external events two to four latch on either transition
    wmes_edge_detect #(
        .N(3)
    ) u_evt_edges (
        .clk(clk),
        .reset(reset),
        .level_in({fixed_src.ext_event_four, fixed_src.ext_event_two, fixed_src.ext_event_three}),
        .edge_sel({3{WMES_EDGE_EITHER}}),
        .hit_q(evt_hit)
    );

    // spelled out: a continuous assign would not see the bus signals read inside wr_at
    assign hib_load = cpu_wr && (cpu_addr == WMES_ADDR_HIB_COUNT);

    wmes_hib_timer #(
        .STEP_TICKS(HIB_STEP_TICKS)
    ) u_hib (
        .clk(clk),
        .reset(reset),
        .slow_clk_32k(slow_clk_32k),
        .load(hib_load),
        .load_val(cpu_wdata),
        .count_q(hib_count),
        .expire_q(hib_expire)
    );

    // level sources set their bit every cycle they are asserted
    assign set_one = {fixed_src.pm_control_two, fixed_src.pm_enable_two, fixed_src.pm_status_two,
                      fixed_src.twowire_one, fixed_src.twowire_two,
                      fixed_src.infrared_receive_wake, fixed_src.ext_event_one,
                      fixed_src.clock_alarm_wake};

    always_comb begin
        set_two = 8'h00;
        set_two[WMES_B2_RING] = fixed_src.serial_ring_indicate;
        set_two[WMES_B2_EVT_FOUR] = evt_hit[2];
        set_two[WMES_B2_EVT_TWO] = evt_hit[1];
        set_two[WMES_B2_EVT_THREE] = evt_hit[0];
        set_two[WMES_B2_HIB] = hib_expire;
        set_two[WMES_B2_ANY_KEY] = fixed_src.any_key_wake;
        set_two[WMES_B2_GP_PIN] = ~fixed_src.general_wake_pin_n;
    end

    assign set_seven = {5'h00, fixed_src.floppy_on_parallel_wake, fixed_src.fan_tach_two,
                        fixed_src.fan_tach_one};

    // latching ignores the masks, so masked events stay visible
    always_ff @(posedge clk) begin
        if (reset) begin
            src_one_q <= WMES_REG_RESET;
            src_two_q <= WMES_REG_RESET;
            src_four_q <= WMES_REG_RESET;
            src_five_q <= WMES_REG_RESET;
            src_six_q <= WMES_REG_RESET;
            src_seven_q <= WMES_REG_RESET;
            src_eight_q <= WMES_REG_RESET;
        end else begin
            src_one_q <= wmes_w1c(src_one_q, set_one,
                                  wr_at(WMES_ADDR_SRC_ONE), cpu_wdata);
            src_two_q <= wmes_w1c(src_two_q, set_two,
                                  wr_at(WMES_ADDR_SRC_TWO), cpu_wdata);
            src_four_q <= wmes_w1c(src_four_q, sel_hit[7:0],
                                   wr_at(WMES_ADDR_SRC_FOUR), cpu_wdata);
            src_five_q <= wmes_w1c(src_five_q, sel_hit[15:8],
                                   wr_at(WMES_ADDR_SRC_FIVE), cpu_wdata);
            src_six_q <= wmes_w1c(src_six_q, sel_hit[23:16],
                                  wr_at(WMES_ADDR_SRC_SIX), cpu_wdata);
            src_seven_q <= wmes_w1c(src_seven_q, set_seven,
                                    wr_at(WMES_ADDR_SRC_SEVEN), cpu_wdata);
            src_eight_q <= wmes_w1c(src_eight_q, fixed_src.legacy_pin_wake_bits,
                                    wr_at(WMES_ADDR_SRC_EIGHT), cpu_wdata);
        end
    end

    // interrupt outputs, registered to keep them glitch-free toward the core
    always_ff @(posedge clk) begin
        if (reset) begin
            wake_irq_q <= 1'b0;
            line_a_q <= 1'b0;
            line_b_q <= 1'b0;
            line_c_q <= 1'b0;
        end else begin
            wake_irq_q <= wmes_any_open(src_one_q, mask_one_q)
                        | wmes_any_open(src_two_q, mask_two_q)
                        | wmes_any_open(src_seven_q, mask_seven_q)
                        | wmes_any_open(src_eight_q, mask_eight_q);
            line_a_q <= wmes_any_open(src_four_q, mask_four_q);
            line_b_q <= wmes_any_open(src_five_q, mask_five_q);
            line_c_q <= wmes_any_open(src_six_q, mask_six_q);
        end
    end

    // read decode; unmapped addresses read zero
    always_comb begin
        case (cpu_addr)
            WMES_ADDR_MASK_ONE: rdata_d = mask_one_q;
            WMES_ADDR_MASK_TWO: rdata_d = mask_two_q & WMES_TWO_VALID;
            WMES_ADDR_MASK_FOUR: rdata_d = mask_four_q;
            WMES_ADDR_MASK_FIVE: rdata_d = mask_five_q;
            WMES_ADDR_MASK_SIX: rdata_d = mask_six_q;
            WMES_ADDR_MASK_SEVEN: rdata_d = mask_seven_q & WMES_SEVEN_VALID;
            WMES_ADDR_MASK_EIGHT: rdata_d = mask_eight_q;
            WMES_ADDR_EDGE_G0_LOW: rdata_d = edge_g0_low_q;
            WMES_ADDR_HIB_COUNT: rdata_d = hib_count;
            WMES_ADDR_SRC_ONE: rdata_d = src_one_q;
            WMES_ADDR_SRC_TWO: rdata_d = src_two_q & WMES_TWO_VALID;
            WMES_ADDR_SRC_FOUR: rdata_d = src_four_q;
            WMES_ADDR_SRC_FIVE: rdata_d = src_five_q;
            WMES_ADDR_SRC_SIX: rdata_d = src_six_q;
            WMES_ADDR_SRC_SEVEN: rdata_d = src_seven_q & WMES_SEVEN_VALID;
            WMES_ADDR_SRC_EIGHT: rdata_d = src_eight_q;
            default: rdata_d = 8'h00;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            rdata_q <= 8'h00;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= cpu_rd;
            if (cpu_rd) rdata_q <= rdata_d;
        end
    end

    assign cpu_rdata = rdata_q;
    assign cpu_rvalid = rvalid_q;
    assign wake_irq = wake_irq_q;
    assign ext_irq_line_a = line_a_q;
    assign ext_irq_line_b = line_b_q;
    assign ext_irq_line_c = line_c_q;

    chk_mask_blocks_line: assert property (@(posedge clk) disable iff (reset)
        (mask_four_q == 8'hff) |=> !ext_irq_line_a)
        else $error("fully masked group still raised line a");

    chk_open_source_line: assert property (@(posedge clk) disable iff (reset)
        (src_six_q[7] && !mask_six_q[7]) |=> ext_irq_line_c)
        else $error("unmasked latched source did not raise line c");

    chk_masked_still_latched: assert property (@(posedge clk) disable iff (reset)
        (src_four_q[7] && !(cpu_wr && cpu_addr == WMES_ADDR_SRC_FOUR)) |=> src_four_q[7])
        else $error("latched source bit lost without a clear");

    chk_w1c_clears_bit: assert property (@(posedge clk) disable iff (reset)
        (cpu_wr && cpu_addr == WMES_ADDR_SRC_FIVE && cpu_wdata[7] && !sel_hit[15])
        |=> !src_five_q[7])
        else $error("write of one did not clear the source bit");

    chk_set_beats_clear: assert property (@(posedge clk) disable iff (reset)
        (cpu_wr && cpu_addr == WMES_ADDR_SRC_FOUR && cpu_wdata[1] && sel_hit[1])
        |=> src_four_q[1])
        else $error("event lost when cleared in the same cycle");

    chk_mask_two_rsvd: assert property (@(posedge clk) disable iff (reset)
        cpu_rvalid && $past(cpu_addr) == WMES_ADDR_MASK_TWO |-> !cpu_rdata[7])
        else $error("reserved mask two bit read as one");

    chk_masks_reset: assert property (@(posedge clk)
        $past(reset) |-> (mask_one_q == 8'h00 && mask_six_q == 8'h00 && mask_seven_q == 8'h00))
        else $error("mask registers not cleared by reset");

    chk_hib_wakes: assert property (@(posedge clk) disable iff (reset)
        (hib_expire && !mask_two_q[WMES_B2_HIB]) |=> src_two_q[WMES_B2_HIB] ##1 wake_irq)
        else $error("hibernation expiry did not raise a wake");

    chk_rd_mask_one: assert property (@(posedge clk) disable iff (reset)
        (cpu_rd && cpu_addr == WMES_ADDR_MASK_ONE)
        |=> (cpu_rvalid && cpu_rdata == $past(mask_one_q)))
        else $error("mask one read returned a wrong value");

    chk_line_b_masked: assert property (@(posedge clk) disable iff (reset)
        (mask_five_q == 8'hff) [*2] |-> !ext_irq_line_b)
        else $error("fully masked group still raised line b");

endmodule : wmes_top
`default_nettype wire

// ==== tb/wmes_cpu_model.sv ====
// behavioural model of the controller core: counts wake interrupt assertions
`timescale 1ns/100ps
`default_nettype none
module wmes_cpu_model
    import wmes_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic wake_irq,
    output logic [7:0] wake_rises
);
    logic irq_q;
    // the core sees a level, so a new wake is only a rising edge of it
    always_ff @(posedge clk) begin
        if (reset) begin
            irq_q <= 1'b0;
            wake_rises <= 8'h00;
        end else begin
            irq_q <= wake_irq;
            if (wake_irq && !irq_q) begin
                wake_rises <= wake_rises + 8'h01;
            end
        end
    end
endmodule : wmes_cpu_model
`default_nettype wire

// ==== tb/wmes_top_bench.sv ====
// self-checking testbench for the wake mask, edge select and hibernation block
`timescale 1ns/100ps
`default_nettype none
module wmes_top_bench;
    import wmes_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [15:0] cpu_addr = 16'h0000;
    logic cpu_wr = 1'b0;
    logic cpu_rd = 1'b0;
    logic [7:0] cpu_wdata = 8'h00;
    logic [7:0] cpu_rdata;
    logic cpu_rvalid;
    logic slow_clk_32k = 1'b0;
    logic wake_irq;
    wmes_fixed_src_t fixed_src = '0;
    logic [23:0] sel_src = 24'hffffff;
    logic [2:0] ext_irq;
    logic [7:0] wake_rises;
    int error_cnt = 0;
    int total_checks = 0;
    logic [15:0] mask_addr [7] = '{WMES_ADDR_MASK_ONE, WMES_ADDR_MASK_TWO, WMES_ADDR_MASK_FOUR,
        WMES_ADDR_MASK_FIVE, WMES_ADDR_MASK_SIX, WMES_ADDR_MASK_SEVEN, WMES_ADDR_MASK_EIGHT};
    logic [7:0] mask_full [7] = '{8'hff, 8'h7f, 8'hff, 8'hff, 8'hff, 8'h07, 8'hff};
    logic [15:0] src_addr [3] = '{WMES_ADDR_SRC_FOUR, WMES_ADDR_SRC_FIVE, WMES_ADDR_SRC_SIX};
    logic [7:0] hit_exp [4] = '{8'h01, 8'h01, 8'h01, 8'h00};

    always #2 clk = ~clk;

    wmes_top #(.HIB_STEP_TICKS(4)) uut (.clk(clk), .reset(reset), .cpu_addr(cpu_addr),
        .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
        .cpu_rvalid(cpu_rvalid), .slow_clk_32k(slow_clk_32k), .fixed_src(fixed_src),
        .selectable_wake_src(sel_src), .wake_irq(wake_irq), .ext_irq_line_a(ext_irq[0]),
        .ext_irq_line_b(ext_irq[1]), .ext_irq_line_c(ext_irq[2]));
    wmes_cpu_model core (.clk(clk), .reset(reset), .wake_irq(wake_irq), .wake_rises(wake_rises));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk);
        cpu_addr = a;
        cpu_wdata = d;
        cpu_wr = 1'b1;
        @(negedge clk);
        cpu_wr = 1'b0;
    endtask : wr

    // a missing rvalid turns the data unknown so the compare fails
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(negedge clk);
        cpu_addr = a;
        cpu_rd = 1'b1;
        @(negedge clk);
        cpu_rd = 1'b0;
        d = (cpu_rvalid === 1'b1) ? cpu_rdata : 8'hxx;
    endtask : rd

    task automatic tick(input int n);
        repeat (n) begin
            @(negedge clk) slow_clk_32k = 1'b1;
            @(negedge clk) slow_clk_32k = 1'b0;
        end
    endtask : tick

    task automatic test_regs();
        logic [7:0] v;
        for (int i = 0; i < 7; i++) begin
            rd(mask_addr[i], v);
            check(v, WMES_REG_RESET);
            wr(mask_addr[i], 8'hff);
            rd(mask_addr[i], v);
            check(v, mask_full[i]);
            wr(mask_addr[i], 8'h00);
        end
        rd(16'h7f30, v);
        check(v, 8'h00);
    endtask : test_regs

    // top source of each group checks the high end of the bit mapping
    task automatic test_groups();
        logic [7:0] v;
        for (int g = 0; g < 3; g++) begin
            sel_src[8*g+7] = 1'b0;
            repeat (4) @(negedge clk);
            check({5'h00, ext_irq}, 8'(1 << g));
            wr(mask_addr[g+2], 8'h80);
            repeat (2) @(negedge clk);
            check({5'h00, ext_irq}, 8'h00);
            rd(src_addr[g], v);
            check(v, 8'h80);
            wr(src_addr[g], 8'h80);
            wr(mask_addr[g+2], 8'h00);
            rd(src_addr[g], v);
            check(v, 8'h00);
            sel_src[8*g+7] = 1'b1;
        end
    endtask : test_groups

    // a select change may latch a spurious hit, so clear before each edge
    task automatic test_edges();
        logic [7:0] v;
        for (int c = 0; c < 4; c++) begin
            wr(WMES_ADDR_EDGE_G0_LOW, 8'(c));
            repeat (3) @(negedge clk);
            wr(WMES_ADDR_SRC_FOUR, 8'h01);
            sel_src[0] = ~sel_src[0];
            repeat (4) @(negedge clk);
            rd(WMES_ADDR_SRC_FOUR, v);
            check(v, hit_exp[c]);
            wr(WMES_ADDR_SRC_FOUR, 8'h01);
        end
    endtask : test_edges

    task automatic test_hib();
        logic [7:0] v;
        wr(WMES_ADDR_HIB_COUNT, 8'h02);
        tick(3);
        rd(WMES_ADDR_HIB_COUNT, v);
        check(v, 8'h02);
        tick(9);
        rd(WMES_ADDR_HIB_COUNT, v);
        check(v, 8'h00);
        rd(WMES_ADDR_SRC_TWO, v);
        check(v, 8'h04);
        check(wake_rises, 8'h01);
        wr(WMES_ADDR_SRC_TWO, 8'h04);
        wr(WMES_ADDR_MASK_ONE, 8'h01);
        fixed_src.clock_alarm_wake = 1'b1;
        repeat (4) @(negedge clk);
        check({7'h00, wake_irq}, 8'h00);
        rd(WMES_ADDR_SRC_ONE, v);
        check(v, 8'h01);
        fixed_src.ext_event_two = 1'b1;
        fixed_src.general_wake_pin_n = 1'b0;
        repeat (4) @(negedge clk);
        rd(WMES_ADDR_SRC_TWO, v);
        check(v, 8'h11);
    endtask : test_hib

    // a mid-run reset clears the masks; a source held high must not look like an edge
    task automatic test_reset();
        logic [7:0] v;
        wr(WMES_ADDR_MASK_ONE, 8'hff);
        @(negedge clk) reset = 1'b1;
        repeat (2) @(negedge clk);
        reset = 1'b0;
        rd(WMES_ADDR_MASK_ONE, v);
        check(v, WMES_REG_RESET);
        rd(WMES_ADDR_SRC_TWO, v);
        check(v, 8'h01);
    endtask : test_reset

    task automatic final_report();
        $display("checks %0d, errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : final_report

    initial begin
        fixed_src.general_wake_pin_n = 1'b1;
        repeat (2) @(negedge clk);
        reset = 1'b0;
        test_regs();
        test_groups();
        test_edges();
        test_hib();
        test_reset();
        final_report();
    end

    // the tests need about 225 cycles; over forty times that means a hang
    initial begin
        #40000;
        error_cnt++;
        final_report();
    end
endmodule : wmes_top_bench
`default_nettype wire
